// ---- hw/diag_monitor_consts.svh ----
// Purpose: offsets, field layouts and reset values for the diagnostic readout
// Assumes: byte addresses on the 2-wire target, lower page and upper page 00h
// Notes: definitions only
`ifndef DIAG_MONITOR_CONSTS_SVH
`define DIAG_MONITOR_CONSTS_SVH

// 7-bit target address on the 2-wire bus
`define DEV_ADDR 7'h50

// field base addresses, most significant byte first
`define OFF_TEMP 8'h16
`define OFF_VOLT 8'h1A
`define OFF_RX1 8'h22
`define OFF_RX2 8'h24
`define OFF_RX3 8'h26
`define OFF_RX4 8'h28
`define OFF_BIAS1 8'h2A
`define OFF_BIAS2 8'h2C
`define OFF_BIAS3 8'h2E
`define OFF_BIAS4 8'h30

// receive power kind flag, byte 220 of upper page 00h
`define OFF_PWR_KIND 8'hDC
`define BIT_PWR_KIND 3

// low bits forced to zero, below converter resolution
`define ZERO_MASK_TEMP 16'h0000
`define ZERO_MASK_VOLT 16'h0000
`define ZERO_MASK_RX 16'h0000
`define ZERO_MASK_BIAS 16'h0000

`define FIELD_RESET 16'h0000
`define NUM_FIELDS 10
`define BITS_PER_BYTE 4'h8

`endif

// ---- hw/diag_monitor_pkg.sv ----
// Purpose: shared types of the diagnostic readout
// Assumes: constants live in diag_monitor_consts.svh
// Notes: none
package diag_monitor_pkg;

    typedef logic [3:0][15:0] lane_word_t;

    typedef enum logic [8:0] {
        ST_IDLE      = 9'h001,
        ST_ADDR      = 9'h002,
        ST_ADDR_ACK  = 9'h004,
        ST_PTR       = 9'h008,
        ST_PTR_ACK   = 9'h010,
        ST_WDATA     = 9'h020,
        ST_WDATA_ACK = 9'h040,
        ST_RDATA     = 9'h080,
        ST_RDATA_ACK = 9'h100
    } tgt_state_t;

endpackage : diag_monitor_pkg

// ---- hw/diag_field_if.sv ----
// Purpose: carries one measurement field between readout and its holder
// Assumes: single clock domain
// Notes: no clocking block
`timescale 1ns/1ns
interface diag_field_if;
    logic [15:0] meas;
    logic strobe;
    logic lock;
    logic [15:0] value;

    modport holder (input meas, input strobe, input lock, output value);
    modport reader (output meas, output strobe, output lock, input value);
endinterface : diag_field_if

// ---- hw/diag_field_hold.sv ----
// Purpose: holds one 16-bit diagnostic field with deferred update
// Assumes: lock is high while the host is fetching this field
// Notes: one new sample pending at most; a newer one overwrites it
`timescale 1ns/1ns
`include "diag_monitor_consts.svh"
module diag_field_hold #(
    parameter logic [15:0] LOW_MASK = 16'h0000
) (
    input wire logic clk_sys_in,    // system clock
    input wire logic rst_in,        // async reset, active high
    diag_field_if.holder bus        // sample in, held value out
);
    logic [15:0] value_ff;
    logic pend_ff;
    logic [15:0] pend_val_ff;
    logic [15:0] nxt_sample;

    // converter noise below resolution is never shown
    assign nxt_sample = bus.meas & ~LOW_MASK;
    assign bus.value = value_ff;

    // whole word replaced in one edge, never byte by byte
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            value_ff <= `FIELD_RESET;
        end else if (!bus.lock) begin
            if (bus.strobe) begin
                value_ff <= nxt_sample;
            end else if (pend_ff) begin
                value_ff <= pend_val_ff;
            end
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            pend_ff <= 1'b0;
            pend_val_ff <= `FIELD_RESET;
        end else if (bus.lock) begin
            if (bus.strobe) begin
                pend_ff <= 1'b1;
                pend_val_ff <= nxt_sample;
            end
        end else begin
            pend_ff <= 1'b0;
        end
    end

    hold_stable_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        bus.lock && $past(bus.lock) |-> $stable(value_ff))
        else $error("held field changed while locked");

    defer_apply_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        pend_ff && !bus.lock && !bus.strobe |=> value_ff == $past(pend_val_ff))
        else $error("deferred sample not applied after unlock");

    sample_take_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        bus.strobe && !bus.lock |=> value_ff == ($past(bus.meas) & ~LOW_MASK))
        else $error("fresh sample not taken while unlocked");

    low_zero_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (value_ff & LOW_MASK) == 16'h0000)
        else $error("bits below resolution not zero");

endmodule : diag_field_hold

// ---- hw/diag_monitor_readout.sv ----
// Purpose: 2-wire target presenting module and lane diagnostics read-only
// Assumes: scl and sda inputs synchronous to clk_sys_in and slow against it
// Notes: read-only target, host writes acked and dropped
// Behaviour
// - fields are 16 bits, high byte first
// - bits below converter resolution read zero
// - field updates are atomic, never half written
// - field frozen while the host fetches it
// - temperature signed, 1/256 degree per count
// - supply voltage unsigned, 100 uV per count
// - transmit bias unsigned, 2 uA per count
// - receive power unsigned, 0.1 uW per count
// - power kind flag at byte 220 bit 3
// - thresholds share the measurement encoding exactly
// - receive power lanes 1-4 at 34..41
// - transmit bias lanes 1-4 at 42..49
`timescale 1ns/1ns
`include "diag_monitor_consts.svh"
module diag_monitor_readout (
    input wire logic clk_sys_in,                      // system clock, 125 MHz
    input wire logic rst_in,                          // async reset, active high
    input wire logic scl_in,                          // 2-wire clock from host
    input wire logic sda_in,                          // 2-wire data level
    output logic sda_out,                             // data drive value, always low
    output logic sda_oe_n_out,                        // low while pulling data low
    input wire logic meas_strobe_in,                  // one-cycle pulse, new samples
    input wire logic [15:0] temp_meas_in,             // module temperature sample
    input wire logic [15:0] volt_meas_in,             // supply voltage sample
    input wire diag_monitor_pkg::lane_word_t rx_meas_in,   // receive power, lanes 1-4
    input wire diag_monitor_pkg::lane_word_t bias_meas_in, // transmit bias, lanes 1-4
    input wire logic pwr_kind_amp_in                  // 1: modulation amplitude
);
    import diag_monitor_pkg::*;

    localparam logic [7:0] BASE [`NUM_FIELDS] = '{
        `OFF_TEMP, `OFF_VOLT, `OFF_RX1, `OFF_RX2, `OFF_RX3, `OFF_RX4,
        `OFF_BIAS1, `OFF_BIAS2, `OFF_BIAS3, `OFF_BIAS4};
    localparam logic [15:0] MASK [`NUM_FIELDS] = '{
        `ZERO_MASK_TEMP, `ZERO_MASK_VOLT, `ZERO_MASK_RX, `ZERO_MASK_RX,
        `ZERO_MASK_RX, `ZERO_MASK_RX, `ZERO_MASK_BIAS, `ZERO_MASK_BIAS,
        `ZERO_MASK_BIAS, `ZERO_MASK_BIAS};

    tgt_state_t state_ff;
    logic scl_q_ff;
    logic sda_q_ff;
    logic [3:0] bit_cnt_ff;
    logic [7:0] rx_shift_ff;
    logic [7:0] tx_shift_ff;
    logic [7:0] ptr_ff;
    logic rw_ff;
    logic ack_ff;
    logic drive_ff;
    logic [`NUM_FIELDS-1:0] lock_ff;
    logic [15:0] meas_w [`NUM_FIELDS];
    logic [15:0] val_w [`NUM_FIELDS];
    logic [7:0] rd_byte;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    logic byte_load;
    logic addr_match;

    assign scl_rise = scl_in & ~scl_q_ff;
    assign scl_fall = ~scl_in & scl_q_ff;
    assign start_seen = scl_in & scl_q_ff & sda_q_ff & ~sda_in;
    assign stop_seen = scl_in & scl_q_ff & ~sda_q_ff & sda_in;
    assign addr_match = rx_shift_ff[7:1] == `DEV_ADDR;
    assign byte_load = scl_fall && ((state_ff == ST_ADDR_ACK && rw_ff) ||
                                    (state_ff == ST_RDATA_ACK && ack_ff));

    // open drain: only ever pull low
    assign sda_out = 1'b0;
    assign sda_oe_n_out = ~drive_ff;

    // raw codes pass unchanged; alarm thresholds elsewhere use this same scaling
    always_comb begin
        meas_w[0] = temp_meas_in;
        meas_w[1] = volt_meas_in;
        for (int k = 0; k < 4; k++) begin
            meas_w[2+k] = rx_meas_in[k];
            meas_w[6+k] = bias_meas_in[k];
        end
    end

    for (genvar i = 0; i < `NUM_FIELDS; i++) begin : g_fld
        diag_field_if fld ();
        assign fld.meas = meas_w[i];
        assign fld.strobe = meas_strobe_in;
        // lock also on the load edge itself, else a sample there tears the word
        assign fld.lock = lock_ff[i] || (byte_load && ptr_ff == BASE[i]);
        assign val_w[i] = fld.value;
        diag_field_hold #(.LOW_MASK(MASK[i])) u_hold (
            .clk_sys_in(clk_sys_in),
            .rst_in(rst_in),
            .bus(fld)
        );
    end

    // anything not decoded reads zero
    always_comb begin
        rd_byte = 8'h00;
        for (int i = 0; i < `NUM_FIELDS; i++) begin
            if (ptr_ff == BASE[i]) begin
                rd_byte = val_w[i][15:8];
            end
            if (ptr_ff == BASE[i] + 8'h01) begin
                rd_byte = val_w[i][7:0];
            end
        end
        if (ptr_ff == `OFF_PWR_KIND) begin
            rd_byte[`BIT_PWR_KIND] = pwr_kind_amp_in;
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            scl_q_ff <= 1'b1;
            sda_q_ff <= 1'b1;
        end else begin
            scl_q_ff <= scl_in;
            sda_q_ff <= sda_in;
        end
    end

    // bus protocol; start or stop override any state
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            state_ff <= ST_IDLE;
            bit_cnt_ff <= 4'h0;
            rx_shift_ff <= 8'h00;
            tx_shift_ff <= 8'h00;
            rw_ff <= 1'b0;
            ack_ff <= 1'b0;
            drive_ff <= 1'b0;
        end else if (start_seen) begin
            state_ff <= ST_ADDR;
            bit_cnt_ff <= 4'h0;
            drive_ff <= 1'b0;
        end else if (stop_seen) begin
            state_ff <= ST_IDLE;
            drive_ff <= 1'b0;
        end else if (scl_rise) begin
            unique case (state_ff)
                ST_ADDR, ST_PTR, ST_WDATA: begin
                    rx_shift_ff <= {rx_shift_ff[6:0], sda_in};
                    bit_cnt_ff <= bit_cnt_ff + 4'h1;
                end
                ST_RDATA_ACK: begin
                    ack_ff <= ~sda_in;
                end
                ST_IDLE, ST_ADDR_ACK, ST_PTR_ACK, ST_WDATA_ACK, ST_RDATA: begin
                end
            endcase
        end else if (scl_fall) begin
            unique case (state_ff)
                ST_IDLE: begin
                end
                ST_ADDR: begin
                    if (bit_cnt_ff == `BITS_PER_BYTE) begin
                        if (addr_match) begin
                            state_ff <= ST_ADDR_ACK;
                            rw_ff <= rx_shift_ff[0];
                            drive_ff <= 1'b1;
                        end else begin
                            state_ff <= ST_IDLE;
                        end
                    end
                end
                ST_PTR, ST_WDATA: begin
                    if (bit_cnt_ff == `BITS_PER_BYTE) begin
                        state_ff <= (state_ff == ST_PTR) ? ST_PTR_ACK : ST_WDATA_ACK;
                        drive_ff <= 1'b1;
                    end
                end
                ST_ADDR_ACK, ST_RDATA_ACK: begin
                    if (byte_load) begin
                        state_ff <= ST_RDATA;
                        tx_shift_ff <= rd_byte;
                        drive_ff <= ~rd_byte[7];
                        bit_cnt_ff <= 4'h1;
                    end else if (state_ff == ST_ADDR_ACK) begin
                        state_ff <= ST_PTR;
                        bit_cnt_ff <= 4'h0;
                        drive_ff <= 1'b0;
                    end else begin
                        // host said no more: wait for stop
                        state_ff <= ST_IDLE;
                        drive_ff <= 1'b0;
                    end
                end
                ST_PTR_ACK, ST_WDATA_ACK: begin
                    state_ff <= ST_WDATA;
                    bit_cnt_ff <= 4'h0;
                    drive_ff <= 1'b0;
                end
                ST_RDATA: begin
                    if (bit_cnt_ff == `BITS_PER_BYTE) begin
                        state_ff <= ST_RDATA_ACK;
                        drive_ff <= 1'b0;
                    end else begin
                        tx_shift_ff <= {tx_shift_ff[6:0], 1'b0};
                        drive_ff <= ~tx_shift_ff[6];
                        bit_cnt_ff <= bit_cnt_ff + 4'h1;
                    end
                end
            endcase
        end
    end

    // data bytes written by the host are acknowledged and dropped
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            ptr_ff <= 8'h00;
        end else if (scl_fall && state_ff == ST_PTR && bit_cnt_ff == `BITS_PER_BYTE) begin
            ptr_ff <= rx_shift_ff;
        end else if (scl_fall && state_ff == ST_WDATA && bit_cnt_ff == `BITS_PER_BYTE) begin
            ptr_ff <= ptr_ff + 8'h01;
        end else if (byte_load) begin
            ptr_ff <= ptr_ff + 8'h01;
        end
    end

    // freeze a field from its high byte until a byte other than its low byte loads, or the frame end
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            lock_ff <= '0;
        end else if (start_seen || stop_seen) begin
            lock_ff <= '0;
        end else if (byte_load) begin
            for (int i = 0; i < `NUM_FIELDS; i++) begin
                if (ptr_ff == BASE[i]) begin
                    lock_ff[i] <= 1'b1;
                end else if (ptr_ff != BASE[i] + 8'h01) begin
                    lock_ff[i] <= 1'b0;
                end
            end
        end
    end

    sequence s_temp_msb;
        byte_load && ptr_ff == `OFF_TEMP;
    endsequence

    sequence s_temp_lsb;
        byte_load && ptr_ff == `OFF_TEMP + 8'h01;
    endsequence

    temp_msb_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        s_temp_msb |=> tx_shift_ff == $past(val_w[0][15:8]))
        else $error("temperature high byte not sent first");

    temp_lock_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        s_temp_msb |-> g_fld[0].fld.lock ##1 lock_ff[0])
        else $error("temperature field not frozen from its high byte");

    // a lone low byte read is left unprotected
    lock_keep_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        lock_ff[0] && !start_seen && !stop_seen && !byte_load |=> lock_ff[0])
        else $error("temperature field released mid transfer");

    stop_unlock_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        stop_seen |=> lock_ff == '0 && !drive_ff)
        else $error("field lock or data drive left after stop");

    temp_lsb_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        s_temp_lsb |=> tx_shift_ff == $past(g_fld[0].fld.value[7:0]))
        else $error("temperature low byte wrong");

    volt_map_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        byte_load && ptr_ff == `OFF_VOLT |=> tx_shift_ff == $past(val_w[1][15:8]))
        else $error("voltage high byte wrong");

    volt_lsb_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        byte_load && ptr_ff == `OFF_VOLT + 8'h01 |=> tx_shift_ff == $past(val_w[1][7:0]))
        else $error("voltage low byte wrong");

    rx4_map_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        byte_load && ptr_ff == `OFF_RX4 + 8'h01 |=> tx_shift_ff == $past(val_w[5][7:0]))
        else $error("lane 4 receive power low byte wrong");

    rx1_map_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        byte_load && ptr_ff == `OFF_RX1 |=> tx_shift_ff == $past(val_w[2][15:8]))
        else $error("lane 1 receive power high byte wrong");

    bias4_map_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        byte_load && ptr_ff == `OFF_BIAS4 + 8'h01 |=> tx_shift_ff == $past(val_w[9][7:0]))
        else $error("lane 4 bias low byte wrong");

    bias1_map_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        byte_load && ptr_ff == `OFF_BIAS1 |=> tx_shift_ff == $past(val_w[6][15:8]))
        else $error("lane 1 bias high byte wrong");

    pwr_kind_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        byte_load && ptr_ff == `OFF_PWR_KIND
        |=> tx_shift_ff == {4'h0, $past(pwr_kind_amp_in), 3'h0})
        else $error("power kind flag byte wrong");

    reserved_zero_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        byte_load && ptr_ff == `OFF_TEMP + 8'h02 |=> tx_shift_ff == 8'h00)
        else $error("reserved byte not zero");

endmodule : diag_monitor_readout

// ---- testbench/diag_host_model.sv ----
// Purpose: 2-wire host master model driving the readout's serial pins
// Assumes: sda_in is the resolved wire with pull-up
// Notes: reports each ack bit and each received byte as one result pulse
`timescale 1ns/1ns
module diag_host_model (
    input wire logic clk_sys_in,      // system clock
    input wire logic sda_in,          // resolved data wire
    output logic scl_out,             // 2-wire clock
    output logic sda_oe_n_out,        // low while pulling data low
    output logic result_valid_out,    // one-cycle pulse per result
    output logic [8:0] result_out     // {is_ack, ack bit or data byte}
);
    // phases well above the 4 clocks the target needs
    localparam int PHASE = 8;
    initial begin
        scl_out = 1'b1;
        sda_oe_n_out = 1'b1;
        result_valid_out = 1'b0;
        result_out = 9'h000;
    end
    task automatic hold(input int n);
        repeat (n) @(posedge clk_sys_in);
        #1;
    endtask : hold
    task automatic emit(input logic [8:0] r);
        result_out = r;
        result_valid_out = 1'b1;
        hold(1);
        result_valid_out = 1'b0;
    endtask : emit
    // data only changes while scl is low, so no false start or stop
    task automatic bit_out(input logic b);
        sda_oe_n_out = b;
        hold(PHASE);
        scl_out = 1'b1;
        hold(PHASE);
        scl_out = 1'b0;
        hold(PHASE);
    endtask : bit_out
    task automatic bit_in(output logic b);
        sda_oe_n_out = 1'b1;
        hold(PHASE);
        scl_out = 1'b1;
        hold(PHASE);
        b = sda_in;
        scl_out = 1'b0;
        hold(PHASE);
    endtask : bit_in
    task automatic start_cond();
        sda_oe_n_out = 1'b1;
        hold(PHASE);
        scl_out = 1'b1;
        hold(PHASE);
        sda_oe_n_out = 1'b0;
        hold(PHASE);
        scl_out = 1'b0;
        hold(PHASE);
    endtask : start_cond
    task automatic stop_cond();
        sda_oe_n_out = 1'b0;
        hold(PHASE);
        scl_out = 1'b1;
        hold(PHASE);
        sda_oe_n_out = 1'b1;
        hold(PHASE);
    endtask : stop_cond
    task automatic send_byte(input logic [7:0] b);
        logic a;
        for (int i = 7; i >= 0; i--) bit_out(b[i]);
        bit_in(a);
        emit({1'b1, 7'h00, a});
    endtask : send_byte
    task automatic recv_byte(input logic last);
        logic [7:0] d;
        for (int i = 7; i >= 0; i--) bit_in(d[i]);
        emit({1'b0, d});
        bit_out(last); // acking the high byte keeps both bytes in one read
    endtask : recv_byte
endmodule : diag_host_model

// ---- testbench/diag_monitor_readout_test.sv ----
// Purpose: self-checking bench for the diagnostic readout
// Assumes: default zero masks, target address from the constants header
// Notes: driver queues expectations, monitor compares each result
`timescale 1ns/1ns
`include "diag_monitor_consts.svh"
module diag_monitor_readout_test;
    import diag_monitor_pkg::*;
    logic clk_sys_in, rst_in, scl, sda, sda_dev, dev_oe_n, host_oe_n;
    logic strobe, kind_d, res_valid;
    logic [15:0] temp_d, volt_d;
    lane_word_t rx_d, bias_d;
    logic [8:0] res, exp_v;
    logic [8:0] exp_q[$];
    logic [31:0] seed;
    int miscompares, tests_run;
    assign sda = (dev_oe_n | sda_dev) & host_oe_n;
    diag_monitor_readout u_diag_monitor_readout (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
        .scl_in(scl), .sda_in(sda), .sda_out(sda_dev), .sda_oe_n_out(dev_oe_n),
        .meas_strobe_in(strobe), .temp_meas_in(temp_d), .volt_meas_in(volt_d),
        .rx_meas_in(rx_d), .bias_meas_in(bias_d), .pwr_kind_amp_in(kind_d));
    diag_host_model u_diag_host_model (.clk_sys_in(clk_sys_in), .sda_in(sda), .scl_out(scl),
        .sda_oe_n_out(host_oe_n), .result_valid_out(res_valid), .result_out(res));
    initial begin
        clk_sys_in = 1'b0;
        forever #4 clk_sys_in = ~clk_sys_in;
    end
    function automatic logic [31:0] xorshift(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xorshift
    function automatic logic [7:0] exp_byte(input logic [7:0] a);
        logic [15:0] f;
        f = 16'h0000;
        if (a == `OFF_PWR_KIND) return {4'h0, kind_d, 3'h0};
        if (a == `OFF_TEMP || a == `OFF_TEMP + 8'h01) f = temp_d;
        if (a == `OFF_VOLT || a == `OFF_VOLT + 8'h01) f = volt_d;
        if (a >= `OFF_RX1 && a <= `OFF_RX4 + 8'h01) f = rx_d[(a - `OFF_RX1) >> 1];
        if (a >= `OFF_BIAS1 && a <= `OFF_BIAS4 + 8'h01) f = bias_d[(a - `OFF_BIAS1) >> 1];
        return a[0] ? f[7:0] : f[15:8];
    endfunction : exp_byte
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys_in);
        #1;
    endtask : step
    task automatic results();
        $display("counts: %0d compared, %0d mismatched", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : results
    // expectations are queued before the bus moves, from today's samples
    task automatic rd(input logic [7:0] p, input int n);
        repeat (3) exp_q.push_back(9'h100);
        for (int i = 0; i < n; i++) exp_q.push_back({1'b0, exp_byte(p + 8'(i))});
        u_diag_host_model.start_cond();
        u_diag_host_model.send_byte({`DEV_ADDR, 1'b0});
        u_diag_host_model.send_byte(p);
        u_diag_host_model.start_cond();
        u_diag_host_model.send_byte({`DEV_ADDR, 1'b1});
        for (int i = 0; i < n; i++) u_diag_host_model.recv_byte(i == n - 1);
        u_diag_host_model.stop_cond();
    endtask : rd
    task automatic wr(input logic [7:0] p, input logic [7:0] d);
        repeat (3) exp_q.push_back(9'h100);
        u_diag_host_model.start_cond();
        u_diag_host_model.send_byte({`DEV_ADDR, 1'b0});
        u_diag_host_model.send_byte(p);
        u_diag_host_model.send_byte(d);
        u_diag_host_model.stop_cond();
    endtask : wr
    task automatic rnd_sample();
        for (int k = 0; k < 4; k++) begin
            seed = xorshift(seed);
            rx_d[k] = seed[15:0];
            bias_d[k] = seed[31:16];
        end
        seed = xorshift(seed);
        temp_d = seed[15:0];
        volt_d = seed[31:16];
        strobe = 1'b1;
        step(1);
        strobe = 1'b0;
    endtask : rnd_sample
    always @(posedge clk_sys_in) begin
        if (res_valid === 1'b1) begin
            tests_run++;
            if (exp_q.size() == 0) begin
                miscompares++;
                $display("unexpected result: expected none seen %h", res);
            end else begin
                exp_v = exp_q.pop_front();
                if (res !== exp_v) begin
                    miscompares++;
                    $display("unexpected result: expected %h seen %h", exp_v, res);
                end
            end
        end
    end
    initial begin
        seed = 32'h00000061;
        {rst_in, strobe, kind_d, temp_d, volt_d} = {3'b100, 32'h00000000};
        rx_d = '0;
        bias_d = '0;
        miscompares = 0;
        tests_run = 0;
        step(8);
        rst_in = 1'b0;
        step(4);
        rd(`OFF_TEMP, 28);
        $display("test reset_values done");
        for (int it = 0; it < 3; it++) begin
            kind_d = it[0];
            step(1);
            rnd_sample();
            rd(`OFF_TEMP, 28);
            rd(`OFF_PWR_KIND, 1);
        end
        $display("test field_map done");
        wr(`OFF_TEMP, 8'hFF);
        wr(8'h18, 8'hA5);
        rd(`OFF_TEMP, 4);
        $display("test writes_ignored done");
        exp_q.push_back(9'h101);
        u_diag_host_model.start_cond();
        u_diag_host_model.send_byte({7'h51, 1'b0});
        u_diag_host_model.stop_cond();
        rd(`OFF_VOLT, 2);
        $display("test wrong_address done");
        fork
            rd(`OFF_TEMP, 2);
            begin
                int n;
                for (n = 0; n < 4000; n++) begin
                    @(posedge clk_sys_in);
                    if (res_valid === 1'b1 && res[8] === 1'b0) break;
                end
                if (n == 4000) begin
                    miscompares++;
                    $display("unexpected wait: expected high byte seen timeout");
                end else begin
                    #1;
                    // two samples back to back while locked, the later one wins
                    temp_d = 16'h8000;
                    strobe = 1'b1;
                    step(1);
                    temp_d = 16'h7FFF;
                    step(1);
                    strobe = 1'b0;
                end
            end
        join
        rd(`OFF_TEMP, 2);
        $display("test coherent_read done");
        for (int w = 0; w < 100 && exp_q.size() != 0; w++) step(1);
        if (exp_q.size() != 0) begin
            miscompares++;
            $display("unexpected pending: expected 0 seen %0d", exp_q.size());
        end
        results();
    end
endmodule : diag_monitor_readout_test
